//--- design/ddrc_cfg.svh
`ifndef DDRC_CFG_SVH
`define DDRC_CFG_SVH

// ========================
// phase grid: sixteen steps of clk_i make one full-rate period
`define DDRC_STEP_W         4
`define DDRC_HALF_BIT       4
`define DDRC_FULL_BIT       3
`define DDRC_STEPS_LAST     4'hF
`define DDRC_SCAN_END       5'h10

// ========================
// tap offsets in steps (a tap with offset k rises k steps late)
`define DDRC_OFS_ZERO       4'h0
`define DDRC_OFS_LEAD_90    4'hC
`define DDRC_OFS_LAG_90     4'h4
`define DDRC_OFS_180        4'h8

// ========================
// timing
`define DDRC_CLK_PERIOD_NS  40
`define DDRC_LOCK_TIME_NS   2000
`define DDRC_STABLE_TIME_NS 4000
`define DDRC_LOCK_CYC       8'((`DDRC_LOCK_TIME_NS + `DDRC_CLK_PERIOD_NS - 1) / `DDRC_CLK_PERIOD_NS)
`define DDRC_STABLE_CYC     8'((`DDRC_STABLE_TIME_NS + `DDRC_CLK_PERIOD_NS - 1) / `DDRC_CLK_PERIOD_NS)
`define DDRC_SCAN_MAX_MHZ   100
`define DDRC_SCAN_DIV       4'h2
`define DDRC_CAL_SETTLE     6'h20
`define DDRC_TRACK_WIN      5'h10
`define DDRC_TRACK_HI       5'h0C
`define DDRC_TRACK_LO       5'h04

`endif

//--- design/ddrc_clk_tap.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddrc_cfg.svh"

module ddrc_clk_tap (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // phase grid
    input  wire logic                    run_i,
    input  wire logic [`DDRC_STEP_W-1:0] phase_i,
    input  wire logic [`DDRC_STEP_W-1:0] offset_i,
    // generated clock
    output logic                         clk_o
);

    logic [`DDRC_STEP_W-1:0] diff;

    // ============================================================
    // high for the first half of the period after the offset
    assign diff = phase_i - offset_i;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            clk_o <= 1'b0;
        else
            clk_o <= run_i & ~diff[`DDRC_FULL_BIT];
    end

endmodule
`default_nettype wire

//--- design/ddrc_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddrc_cfg.svh"

module ddrc_clock_gen (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // pin straps and status
    input  wire logic                    full_rate_i,
    input  wire logic [1:0]              ac_phase_i,
    input  wire logic                    ref_stable_i,
    input  wire logic                    synth_reset_i,
    input  wire logic                    mimic_fb_i,
    // calibration from controller logic
    input  wire logic                    cal_start_i,
    input  wire logic                    read_ok_i,
    // generated clocks
    output logic                         controller_core_clock_o,
    output logic                         memory_full_speed_clock_o,
    output logic                         write_data_clock_o,
    output logic                         address_command_clock_o,
    output logic                         chip_select_clock_o,
    output logic                         read_resynchronization_clock_o,
    output logic                         drift_measurement_clock_o,
    output logic                         scan_clock_o,
    // status
    output logic                         synth_locked_o,
    output logic                         clocks_rst_n_o,
    output logic                         relock_needed_o,
    output logic                         cal_done_o,
    output logic                         cal_fail_o,
    output logic [`DDRC_STEP_W-1:0]      resync_phase_o
);

    localparam int N_TAPS  = 6;
    localparam int T_MEM   = 0;
    localparam int T_WRITE = 1;
    localparam int T_AC    = 2;
    localparam int T_CS    = 3;
    localparam int T_RSYNC = 4;
    localparam int T_MEAS  = 5;

    ddrc_pkg::ddrc_sy_state_t sy_state_reg;
    logic [5:0]              sync1_reg;
    logic [5:0]              sync2_reg;
    logic                    full_s;
    logic [1:0]              ac_phase_s;
    logic                    ref_stable_s;
    logic                    synth_reset_s;
    logic                    mimic_s;
    logic [7:0]              lock_cnt_reg;
    logic                    relock_reg;
    logic                    run;
    logic [`DDRC_HALF_BIT:0] phase_cnt_reg;
    logic [`DDRC_STEP_W-1:0] tap_ofs [N_TAPS];
    logic [N_TAPS-1:0]       tap_clk;
    logic [`DDRC_STEP_W-1:0] ac_ofs;
    logic [`DDRC_STEP_W-1:0] cal_phase;
    logic                    cal_sweeping;
    logic                    cal_done;
    logic [`DDRC_STEP_W-1:0] drift_reg;
    logic                    meas_prev_reg;
    logic                    meas_rise;
    logic [4:0]              win_cnt_reg;
    logic [4:0]              vote_reg;
    logic                    half_reg;
    logic                    half_prev_reg;
    logic [3:0]              scan_cnt_reg;
    logic                    scan_reg;

    // ============================================================
    // pin synchronisers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end
        else
        begin
            sync1_reg <= {mimic_fb_i, synth_reset_i, ref_stable_i, ac_phase_i, full_rate_i};
            sync2_reg <= sync1_reg;
        end
    end

    assign full_s        = sync2_reg[0];
    assign ac_phase_s    = sync2_reg[2:1];
    assign ref_stable_s  = sync2_reg[3];
    assign synth_reset_s = sync2_reg[4];
    assign mimic_s       = sync2_reg[5];

    // ============================================================
    // lock sequence; manual reset restarts it from scratch
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sy_state_reg <= ddrc_pkg::SY_RESET;
            lock_cnt_reg <= 8'h00;
        end
        else if (synth_reset_s)
        begin
            sy_state_reg <= ddrc_pkg::SY_RESET;
            lock_cnt_reg <= 8'h00;
        end
        else
        begin
            unique case (sy_state_reg)
                ddrc_pkg::SY_RESET:
                    if (ref_stable_s)
                        sy_state_reg <= ddrc_pkg::SY_LOCKING;
                ddrc_pkg::SY_LOCKING:
                    if (lock_cnt_reg == `DDRC_LOCK_CYC - 8'h01)
                    begin
                        sy_state_reg <= ddrc_pkg::SY_LOCKED;
                        lock_cnt_reg <= 8'h00;
                    end
                    else
                        lock_cnt_reg <= lock_cnt_reg + 8'h01;
                ddrc_pkg::SY_LOCKED:
                    if (lock_cnt_reg == `DDRC_STABLE_CYC - 8'h01)
                        sy_state_reg <= ddrc_pkg::SY_STABLE;
                    else
                        lock_cnt_reg <= lock_cnt_reg + 8'h01;
                ddrc_pkg::SY_STABLE:
                    lock_cnt_reg <= 8'h00;
            endcase
        end
    end

    // an input glitch after start leaves phases untrustworthy until a
    // manual reset; a glitch in the clearing cycle still sets the flag
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            relock_reg <= 1'b0;
        else if (!ref_stable_s && sy_state_reg != ddrc_pkg::SY_RESET)
            relock_reg <= 1'b1;
        else if (synth_reset_s)
            relock_reg <= 1'b0;
    end

    assign run = (sy_state_reg != ddrc_pkg::SY_RESET);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            synth_locked_o  <= 1'b0;
            clocks_rst_n_o  <= 1'b0;
            relock_needed_o <= 1'b0;
        end
        else
        begin
            synth_locked_o  <= (sy_state_reg == ddrc_pkg::SY_LOCKED) |
                               (sy_state_reg == ddrc_pkg::SY_STABLE);
            clocks_rst_n_o  <= (sy_state_reg == ddrc_pkg::SY_STABLE) & ~relock_reg;
            relock_needed_o <= relock_reg;
        end
    end

    // ============================================================
    // phase grid, shared by both design rates
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_cnt_reg <= '0;
        else if (!run)
            phase_cnt_reg <= '0;
        else
            phase_cnt_reg <= phase_cnt_reg + 1'b1;
    end

    // ============================================================
    // address/command source select
    always_comb
    begin
        unique case (ddrc_pkg::ddrc_ac_phase_t'(ac_phase_s))
            ddrc_pkg::AC_PH_0:   ac_ofs = `DDRC_OFS_ZERO;
            ddrc_pkg::AC_PH_180: ac_ofs = `DDRC_OFS_180;
            ddrc_pkg::AC_PH_270: ac_ofs = `DDRC_OFS_LEAD_90;
            ddrc_pkg::AC_PH_90:  ac_ofs = `DDRC_OFS_LAG_90;
        endcase
    end

    assign tap_ofs[T_MEM]   = `DDRC_OFS_ZERO;
    assign tap_ofs[T_WRITE] = `DDRC_OFS_LEAD_90;
    assign tap_ofs[T_AC]    = ac_ofs;
    assign tap_ofs[T_CS]    = ac_ofs;
    assign tap_ofs[T_RSYNC] = cal_sweeping ? cal_phase : cal_phase + drift_reg;
    assign tap_ofs[T_MEAS]  = cal_phase + drift_reg;

    // ============================================================
    // every full-rate clock but the core clock comes out of the same tap structure, so the
    // measurement and resync clocks see identical paths
    genvar gi;
    generate
        for (gi = 0; gi < N_TAPS; gi++)
        begin : g_tap
            ddrc_clk_tap u_tap (
                .clk_i    (clk_i),
                .rst_n_i  (rst_n_i),
                .run_i    (run),
                .phase_i  (phase_cnt_reg[`DDRC_STEP_W-1:0]),
                .offset_i (tap_ofs[gi]),
                .clk_o    (tap_clk[gi])
            );
        end
    endgenerate

    assign memory_full_speed_clock_o      = tap_clk[T_MEM];
    assign write_data_clock_o             = tap_clk[T_WRITE];
    assign address_command_clock_o        = tap_clk[T_AC];
    assign chip_select_clock_o            = tap_clk[T_CS];
    assign read_resynchronization_clock_o = tap_clk[T_RSYNC];
    assign drift_measurement_clock_o      = tap_clk[T_MEAS];

    // ============================================================
    // core clock: half rate at zero phase, or the memory clock itself
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            half_reg                <= 1'b0;
            controller_core_clock_o <= 1'b0;
        end
        else
        begin
            half_reg <= run & ~phase_cnt_reg[`DDRC_HALF_BIT];
            controller_core_clock_o <= run & (full_s ? ~phase_cnt_reg[`DDRC_FULL_BIT]
                                                     : ~phase_cnt_reg[`DDRC_HALF_BIT]);
        end
    end

    // scan clock divides the half-rate clock; it sits far under the
    // DDRC_SCAN_MAX_MHZ ceiling at any grid rate
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            half_prev_reg <= 1'b0;
            scan_cnt_reg  <= 4'h0;
            scan_reg      <= 1'b0;
        end
        else
        begin
            half_prev_reg <= half_reg;
            if (!run)
            begin
                scan_cnt_reg <= 4'h0;
                scan_reg     <= 1'b0;
            end
            else if (half_reg & ~half_prev_reg)
            begin
                if (scan_cnt_reg == `DDRC_SCAN_DIV - 4'h1)
                begin
                    scan_cnt_reg <= 4'h0;
                    scan_reg     <= ~scan_reg;
                end
                else
                    scan_cnt_reg <= scan_cnt_reg + 4'h1;
            end
        end
    end

    assign scan_clock_o = scan_reg;

    // ============================================================
    // resync calibration
    ddrc_resync_cal u_cal (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .run_i      (clocks_rst_n_o),
        .start_i    (cal_start_i),
        .read_ok_i  (read_ok_i),
        .phase_o    (cal_phase),
        .sweeping_o (cal_sweeping),
        .done_o     (cal_done),
        .fail_o     (cal_fail_o)
    );

    assign cal_done_o     = cal_done;
    assign resync_phase_o = tap_ofs[T_RSYNC];

    // ============================================================
    // drift tracking: sample the mimic return at each measurement rise but
    // the last of each window, where the votes decide; one step per window keeps the loop slow and glitch proof
    assign meas_rise = tap_clk[T_MEAS] & ~meas_prev_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meas_prev_reg <= 1'b0;
            win_cnt_reg   <= 5'h00;
            vote_reg      <= 5'h00;
            drift_reg     <= `DDRC_OFS_ZERO;
        end
        else
        begin
            meas_prev_reg <= tap_clk[T_MEAS];
            if (cal_sweeping || !cal_done)
            begin
                win_cnt_reg <= 5'h00;
                vote_reg    <= 5'h00;
                drift_reg   <= `DDRC_OFS_ZERO;
            end
            else if (meas_rise)
            begin
                if (win_cnt_reg == `DDRC_TRACK_WIN - 5'h01)
                begin
                    win_cnt_reg <= 5'h00;
                    vote_reg    <= 5'h00;
                    if (vote_reg >= `DDRC_TRACK_HI)
                        drift_reg <= drift_reg - 4'h1;
                    else if (vote_reg <= `DDRC_TRACK_LO)
                        drift_reg <= drift_reg + 4'h1;
                end
                else
                begin
                    win_cnt_reg <= win_cnt_reg + 5'h01;
                    vote_reg    <= vote_reg + {4'h0, mimic_s};
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- design/ddrc_pkg.sv
package ddrc_pkg;

    // ============================================================
    // synthesizer lock sequence
    typedef enum logic [1:0] {
        SY_RESET   = 2'h0,
        SY_LOCKING = 2'h1,
        SY_LOCKED  = 2'h3,
        SY_STABLE  = 2'h2
    } ddrc_sy_state_t;

    // ============================================================
    // resync calibration sweep
    typedef enum logic [1:0] {
        CAL_IDLE  = 2'h0,
        CAL_SWEEP = 2'h1,
        CAL_SCAN  = 2'h3,
        CAL_DONE  = 2'h2
    } ddrc_cal_state_t;

    // ============================================================
    // address/command phase select
    typedef enum logic [1:0] {
        AC_PH_0   = 2'h0,
        AC_PH_90  = 2'h1,
        AC_PH_180 = 2'h2,
        AC_PH_270 = 2'h3
    } ddrc_ac_phase_t;

endpackage

//--- design/ddrc_resync_cal.sv
`timescale 1ns/100ps
`default_nettype none
`include "ddrc_cfg.svh"

module ddrc_resync_cal (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // control
    input  wire logic                    run_i,
    input  wire logic                    start_i,
    input  wire logic                    read_ok_i,
    // result
    output logic [`DDRC_STEP_W-1:0]      phase_o,
    output logic                         sweeping_o,
    output logic                         done_o,
    output logic                         fail_o
);

    ddrc_pkg::ddrc_cal_state_t state_reg;
    logic [15:0]             pass_reg;
    logic [5:0]              settle_reg;
    logic [4:0]              idx_reg;
    logic [4:0]              run_len_reg;
    logic [4:0]              best_len_reg;
    logic [`DDRC_STEP_W-1:0] run_start_reg;
    logic [`DDRC_STEP_W-1:0] best_start_reg;
    logic                    cur;

    assign cur        = (idx_reg < `DDRC_SCAN_END) & pass_reg[idx_reg[3:0]];
    assign sweeping_o = (state_reg == ddrc_pkg::CAL_SWEEP);

    // ============================================================
    // sweep every phase, then centre on the longest passing run
    // runs do not wrap past the last step; a window split there is
    // treated as two runs, which only costs some margin
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg      <= ddrc_pkg::CAL_IDLE;
            pass_reg       <= 16'h0000;
            settle_reg     <= 6'h00;
            idx_reg        <= 5'h00;
            run_len_reg    <= 5'h00;
            best_len_reg   <= 5'h00;
            run_start_reg  <= `DDRC_OFS_ZERO;
            best_start_reg <= `DDRC_OFS_ZERO;
            phase_o        <= `DDRC_OFS_ZERO;
            done_o         <= 1'b0;
            fail_o         <= 1'b0;
        end
        else if (!run_i)
            state_reg <= ddrc_pkg::CAL_IDLE;
        else
        begin
            unique case (state_reg)
                ddrc_pkg::CAL_IDLE:
                    if (start_i)
                    begin
                        state_reg    <= ddrc_pkg::CAL_SWEEP;
                        idx_reg      <= 5'h00;
                        settle_reg   <= 6'h00;
                        done_o       <= 1'b0;
                        fail_o       <= 1'b0;
                        phase_o      <= `DDRC_OFS_ZERO;
                    end
                ddrc_pkg::CAL_SWEEP:
                begin
                    phase_o <= idx_reg[3:0];
                    if (settle_reg == `DDRC_CAL_SETTLE - 6'h01)
                    begin
                        settle_reg             <= 6'h00;
                        pass_reg[idx_reg[3:0]] <= read_ok_i;
                        if (idx_reg[3:0] == `DDRC_STEPS_LAST)
                        begin
                            state_reg    <= ddrc_pkg::CAL_SCAN;
                            idx_reg      <= 5'h00;
                            run_len_reg  <= 5'h00;
                            best_len_reg <= 5'h00;
                        end
                        else
                            idx_reg <= idx_reg + 5'h01;
                    end
                    else
                        settle_reg <= settle_reg + 6'h01;
                end
                ddrc_pkg::CAL_SCAN:
                begin
                    if (cur)
                    begin
                        if (run_len_reg == 5'h00)
                            run_start_reg <= idx_reg[3:0];
                        run_len_reg <= run_len_reg + 5'h01;
                    end
                    else
                    begin
                        if (run_len_reg > best_len_reg)
                        begin
                            best_len_reg   <= run_len_reg;
                            best_start_reg <= run_start_reg;
                        end
                        run_len_reg <= 5'h00;
                    end
                    if (idx_reg == `DDRC_SCAN_END)
                        state_reg <= ddrc_pkg::CAL_DONE;
                    else
                        idx_reg <= idx_reg + 5'h01;
                end
                ddrc_pkg::CAL_DONE:
                begin
                    state_reg <= ddrc_pkg::CAL_IDLE;
                    done_o    <= 1'b1;
                    fail_o    <= (best_len_reg == 5'h00);
                    phase_o   <= best_start_reg + best_len_reg[4:1];
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- tb/ddrc_clock_gen_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ddrc_clock_gen_checker (
    // clock, reset and straps
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       full_rate_i,
    input wire logic [1:0] ac_phase_i,
    input wire logic       ref_stable_i,
    input wire logic       synth_reset_i,
    // generated clocks and status
    input wire logic       controller_core_clock_o,
    input wire logic       memory_full_speed_clock_o,
    input wire logic       write_data_clock_o,
    input wire logic       address_command_clock_o,
    input wire logic       chip_select_clock_o,
    input wire logic       read_resynchronization_clock_o,
    input wire logic       drift_measurement_clock_o,
    input wire logic       scan_clock_o,
    input wire logic       synth_locked_o,
    input wire logic       clocks_rst_n_o,
    input wire logic       relock_needed_o,
    input wire logic       cal_done_o
);
    // ========
    // aliases
    wire mem = memory_full_speed_clock_o;
    wire wr = write_data_clock_o;
    wire core = controller_core_clock_o;
    wire ac = address_command_clock_o;
    wire lck = synth_locked_o;
    wire crst = clocks_rst_n_o;
    wire ac_exp = ac_phase_i[0] ? (wr ^ ~ac_phase_i[1]) : (mem ^ ac_phase_i[1]);
    // a stopped synthesizer is not checked
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i || synth_reset_i || !ref_stable_i);
    sequence s_mem_cycle;
        mem [*8] ##1 !mem [*8] ##1 mem;
    endsequence
    // ========
    // assertions
    a_mem_full_period: assert property ($rose(mem) && lck |-> s_mem_cycle)
        else $error("memory clock period");
    a_write_leads_mem: assert property ($rose(wr) && lck |-> ##4 $rose(mem))
        else $error("write clock lead");
    a_core_on_mem: assert property ($rose(core) |-> $rose(mem))
        else $error("core edge off memory edge");
    a_core_full_rate: assert property (lck && full_rate_i && $past(full_rate_i, 4)
        |-> core == mem) else $error("full-rate core clock");
    a_core_half_rate: assert property ($rose(core) && !full_rate_i
        && !$past(full_rate_i, 4) |-> ##16 $fell(core)) else $error("half-rate core clock");
    a_scan_clk_divide: assert property ($rose(scan_clock_o) && !full_rate_i
        |-> ##64 $fell(scan_clock_o)) else $error("scan clock divide");
    a_ac_phase_src: assert property (lck && ac_phase_i == $past(ac_phase_i, 3)
        && ac_phase_i == $past(ac_phase_i, 4) |-> ac == ac_exp)
        else $error("address clock source");
    a_cs_follows_ac: assert property (lck |-> chip_select_clock_o == ac)
        else $error("chip-select clock");
    a_hold_until_lock: assert property (!lck |-> !crst)
        else $error("reset released unlocked");
    a_release_after_lock: assert property ($rose(lck) && !relock_needed_o
        |-> ##[99:101] $rose(crst)) else $error("reset release time");
    a_meas_on_resync: assert property (cal_done_o && $past(cal_done_o, 2)
        |-> drift_measurement_clock_o == read_resynchronization_clock_o)
        else $error("measure clock off resync");
endmodule
bind ddrc_clock_gen ddrc_clock_gen_checker ddrc_clock_gen_checker_i (.clk_i, .rst_n_i,
    .full_rate_i, .ac_phase_i, .ref_stable_i, .synth_reset_i, .controller_core_clock_o,
    .memory_full_speed_clock_o, .write_data_clock_o, .address_command_clock_o,
    .chip_select_clock_o, .read_resynchronization_clock_o, .drift_measurement_clock_o,
    .scan_clock_o, .synth_locked_o, .clocks_rst_n_o, .relock_needed_o, .cal_done_o);
`default_nettype wire

//--- tb/ddrc_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ddrc_ctl_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // valid window
    input  wire logic [3:0] win_lo_i,
    input  wire logic [3:0] win_hi_i,
    // clocks in
    input  wire logic [3:0] phase_i,
    input  wire logic       meas_i,
    // answers
    output logic            read_ok_o,
    output logic            mimic_o
);
    // ========
    // read and mimic paths
    logic [3:0] fb_reg;
    // an empty window never passes
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            read_ok_o <= 1'b0;
        else
            read_ok_o <= (phase_i >= win_lo_i) && (phase_i <= win_hi_i);
    // mimic path: a late copy of the measurement clock
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            fb_reg <= 4'h0;
        else
            fb_reg <= {fb_reg[2:0], meas_i};
    assign mimic_o = fb_reg[3];
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ========
    // signals
    logic clk_i, rst_n_i, full_rate_i, ref_stable_i, synth_reset_i, mimic_fb_i;
    logic cal_start_i, read_ok_i, controller_core_clock_o, memory_full_speed_clock_o;
    logic write_data_clock_o, address_command_clock_o, chip_select_clock_o;
    logic read_resynchronization_clock_o, drift_measurement_clock_o, scan_clock_o;
    logic synth_locked_o, clocks_rst_n_o, relock_needed_o, cal_done_o, cal_fail_o;
    logic [1:0] ac_phase_i;
    logic [3:0] resync_phase_o, win_lo, win_hi, ra, rb;
    int         error_cnt, checks, seed;
    ddrc_clock_gen ddrc_clock_gen_i (.clk_i, .rst_n_i, .full_rate_i, .ac_phase_i,
        .ref_stable_i, .synth_reset_i, .mimic_fb_i, .cal_start_i, .read_ok_i,
        .controller_core_clock_o, .memory_full_speed_clock_o, .write_data_clock_o,
        .address_command_clock_o, .chip_select_clock_o, .read_resynchronization_clock_o,
        .drift_measurement_clock_o, .scan_clock_o, .synth_locked_o, .clocks_rst_n_o,
        .relock_needed_o, .cal_done_o, .cal_fail_o, .resync_phase_o);
    ddrc_ctl_model ddrc_ctl_model_i (.clk_i, .rst_n_i, .win_lo_i(win_lo), .win_hi_i(win_hi),
        .phase_i(resync_phase_o), .meas_i(drift_measurement_clock_o),
        .read_ok_o(read_ok_i), .mimic_o(mimic_fb_i));
    // ========
    // helpers
    task automatic end_of_test();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // negedge sampling avoids update races
    task automatic wait_high(ref logic s, input int lim);
        for (int n = 0; n < lim && s !== 1'b1; n++)
            @(negedge clk_i);
        chk(s, 1'b1);
    endtask
    // bit 4: empty window fails; else start plus half length
    function automatic logic [4:0] exp_cal(input logic [3:0] lo, hi);
        if (lo > hi)
            return 5'h10;
        return 5'(lo) + ((5'(hi) - 5'(lo) + 5'h01) >> 1);
    endfunction
    task automatic run_cal(input logic [3:0] lo, hi);
        logic [4:0] e;
        e = exp_cal(lo, hi);
        @(posedge clk_i);
        win_lo <= lo;
        win_hi <= hi;
        cal_start_i <= 1'b1;
        @(posedge clk_i);
        cal_start_i <= 1'b0;
        @(negedge clk_i);
        chk(cal_done_o, 1'b0);
        wait_high(cal_done_o, 1000);
        chk(cal_fail_o, e[4]);
        if (!e[4])
            chk(resync_phase_o, e[3:0]);
        repeat (300) @(negedge clk_i);
        if (!e[4])
            chk(resync_phase_o, 4'(e + 5'h01));
    endtask
    // ========
    // stimulus
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        seed = 32'hbea6;
        {rst_n_i, full_rate_i, ac_phase_i, synth_reset_i, cal_start_i} = '0;
        {ref_stable_i, win_lo, win_hi} = {1'b1, 8'h00};
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_high(clocks_rst_n_o, 400);
        chk(synth_locked_o, 1'b1);
        // each ac phase, then a random one
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_i);
            ac_phase_i <= (i < 4) ? 2'(i) : 2'($random(seed));
            repeat (40) @(posedge clk_i);
        end
        run_cal(4'h0, 4'hF);
        run_cal(4'hF, 4'hF);
        run_cal(4'h5, 4'h4);
        for (int i = 0; i < 3; i++)
        begin
            ra = 4'($random(seed));
            rb = 4'($random(seed));
            run_cal(ra < rb ? ra : rb, ra < rb ? rb : ra);
            if (i == 1)
            begin
                // glitch, manual reset, full rate
                @(posedge clk_i);
                ref_stable_i <= 1'b0;
                repeat (6) @(posedge clk_i);
                ref_stable_i <= 1'b1;
                repeat (6) @(negedge clk_i);
                chk(relock_needed_o, 1'b1);
                chk(clocks_rst_n_o, 1'b0);
                @(posedge clk_i);
                synth_reset_i <= 1'b1;
                full_rate_i <= 1'b1;
                repeat (8) @(posedge clk_i);
                synth_reset_i <= 1'b0;
                wait_high(clocks_rst_n_o, 400);
                chk(relock_needed_o, 1'b0);
            end
        end
        repeat (300) @(posedge clk_i);
        end_of_test();
    end
endmodule
`default_nettype wire
